// ### logic/perf_sampling_defs.vh
`ifndef PERF_SAMPLING_DEFS_VH
`define PERF_SAMPLING_DEFS_VH

// Register addresses reached through the register port
`define QUAL0_ADDR 10'h1a6
`define QUAL1_ADDR 10'h1a7
`define CAPAB_ADDR 10'h345

// Capability register: record format field
`define CAPAB_FMT_LSB 8
`define CAPAB_FMT_MSB 11
`define CAPAB_FMT_VAL 4'h2

// Event select codes and unit masks
`define EVT_BRANCHES 8'hc4
`define EVT_MISPRED 8'hc5
`define EVT_MEM_UOPS 8'h04
`define EVT_RECYCLE 8'h03
`define EVT_OFFCORE 8'hb7
`define UNIT_MASK_QUAL0 8'h01
`define UNIT_MASK_QUAL1 8'h02
`define EVT_CORE_CYC 8'h3c
`define EVT_REF_CYC 8'h3c
`define UNIT_MASK_CORE_CYC 8'h00
`define UNIT_MASK_REF_CYC 8'h01

// Qualifier field layout
`define QUAL_REQ_LSB 0
`define QUAL_REQ_MSB 15
`define QUAL_SUP_LSB 16
`define QUAL_SUP_MSB 30
`define QUAL_SNP_LSB 31
`define QUAL_SNP_MSB 37
`define QUAL_LAT_BIT 38
`define QUAL0_MASK 64'h0000_007f_ffff_feff
`define QUAL1_MASK 64'h0000_003f_ffff_ffff

// Record slot layout: byte offsets of 64-bit slots
`define REC_FLAGS 8'h00
`define REC_IP 8'h08
`define REC_GPR0 8'h10
`define REC_GSTAT 8'h90
`define REC_DLA 8'h98
`define REC_RSV0 8'ha0
`define REC_RSV1 8'ha8
`define REC_EVIP 8'hb0
`define REC_RSV2 8'hb8
`define REC_SLOTS 5'd24

`endif

// ### logic/offcore_match.v
`timescale 1ns/1ns
`include "perf_sampling_defs.vh"

// Matches one transaction against a qualifier register
module offcore_match (
  input wire [63:0] qual,
  input wire [15:0] req_type,
  input wire [14:0] supplier,
  input wire [6:0] snoop,
  output wire hit
);
  // Each group must share at least one set bit with the attributes
  assign hit = (|(qual[`QUAL_REQ_MSB:`QUAL_REQ_LSB] & req_type)) &
               (|(qual[`QUAL_SUP_MSB:`QUAL_SUP_LSB] & supplier)) &
               (|(qual[`QUAL_SNP_MSB:`QUAL_SNP_LSB] & snoop));
endmodule // offcore_match

// ### logic/perf_sampling_offcore.v
`timescale 1ns/1ns
`include "perf_sampling_defs.vh"

module perf_sampling_offcore #(
  parameter CNT_W = 48
) (
  input wire mclk,
  input wire rst_b,
  input wire clk_en,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [9:0] reg_addr,
  input wire [63:0] reg_wdata,
  output reg [63:0] reg_rdata,
  output reg reg_err,
  // Event select fields for the two general counters
  input wire [7:0] evsel0_event,
  input wire [7:0] evsel0_unit_mask,
  input wire evsel0_en,
  input wire evsel0_any,
  input wire evsel0_precise_event_sampling,
  input wire [7:0] evsel1_event,
  input wire [7:0] evsel1_unit_mask,
  input wire evsel1_en,
  input wire evsel1_any,
  input wire [2:0] fixed_any_req,
  // Retired event stream and architectural state
  input wire evt_valid,
  input wire [7:0] evt_code,
  input wire [7:0] evt_unit_mask,
  input wire [63:0] evt_dla,
  input wire [63:0] evt_ip,
  input wire next_valid,
  input wire [63:0] next_flags,
  input wire [63:0] next_ip,
  input wire [1023:0] next_gprs,
  input wire [63:0] global_status,
  // Off-core transaction responses
  input wire txn_valid,
  input wire [15:0] txn_req,
  input wire [14:0] txn_sup,
  input wire [6:0] txn_snp,
  input wire [7:0] outstanding,
  // Sample record write port toward the save area
  input wire rec_ready,
  output reg rec_valid,
  output reg [7:0] rec_offset,
  output reg [63:0] rec_data,
  output wire rec_busy,
  // Counters and cross-thread grants
  output reg [CNT_W-1:0] gen_count0,
  output reg [CNT_W-1:0] gen_count1,
  output wire [2:0] fixed_any_ok,
  output wire evsel0_any_ok,
  output wire evsel1_any_ok
);

  // Record state machine
  localparam S_IDLE = 2'b00;
  localparam S_WAIT = 2'b01;
  localparam S_EMIT = 2'b10;

  reg [63:0] qual0_r; // Private qualifier zero of this core
  reg [63:0] qual1_r; // Private qualifier one of this core
  reg [63:0] qual0_act_r; // Copy in force for transactions
  reg [63:0] qual1_act_r;
  reg [1:0] state_r;
  reg [4:0] slot_r; // Current slot index
  reg [63:0] dla_r; // Captured data address
  reg dla_ok_r; // Event supplies an address
  reg [63:0] evip_r; // Causing instruction pointer
  reg [63:0] flags_r;
  reg [63:0] ip_r;
  reg [1023:0] gprs_r;
  reg [63:0] gstat_r;
  reg [63:0] slot_val; // Value for current slot
  wire hit0;
  wire hit1;
  wire lat_en; // Latency measurement active
  wire sel0_q0; // Counter 0 counts with qualifier 0
  wire sel0_q1;
  wire sel1_q0;
  wire sel1_q1;
  wire precise_event_sampling_evt; // Event is a precise sampling event
  wire dla_evt; // Event carries a data address
  wire [63:0] capab;

  // Qualifier matchers, one per register
  offcore_match u_match0 (
    .qual(qual0_act_r),
    .req_type(txn_req),
    .supplier(txn_sup),
    .snoop(txn_snp),
    .hit(hit0)
  );
  offcore_match u_match1 (
    .qual(qual1_act_r),
    .req_type(txn_req),
    .supplier(txn_sup),
    .snoop(txn_snp),
    .hit(hit1)
  );

  // Capability register with record format field
  assign capab = {52'h0, `CAPAB_FMT_VAL, 8'h00};

  // Cross-thread grants: fixed requests pass through, general counters limited to cycle events
  assign fixed_any_ok = fixed_any_req;
  assign evsel0_any_ok = evsel0_any & (evsel0_event == `EVT_CORE_CYC) &
    ((evsel0_unit_mask == `UNIT_MASK_CORE_CYC) | (evsel0_unit_mask == `UNIT_MASK_REF_CYC));
  assign evsel1_any_ok = evsel1_any & (evsel1_event == `EVT_CORE_CYC) &
    ((evsel1_unit_mask == `UNIT_MASK_CORE_CYC) | (evsel1_unit_mask == `UNIT_MASK_REF_CYC));

  // Off-core selection by event code and unit mask
  assign sel0_q0 = evsel0_en & (evsel0_event == `EVT_OFFCORE) &
    (evsel0_unit_mask == `UNIT_MASK_QUAL0);
  assign sel0_q1 = evsel0_en & (evsel0_event == `EVT_OFFCORE) &
    (evsel0_unit_mask == `UNIT_MASK_QUAL1);
  assign sel1_q0 = evsel1_en & (evsel1_event == `EVT_OFFCORE) &
    (evsel1_unit_mask == `UNIT_MASK_QUAL0);
  assign sel1_q1 = evsel1_en & (evsel1_event == `EVT_OFFCORE) &
    (evsel1_unit_mask == `UNIT_MASK_QUAL1);

  // Latency mode needs bit 38 and both counters on qualifier zero
  assign lat_en = qual0_act_r[`QUAL_LAT_BIT] & sel0_q0 & sel1_q0;

  // Precise events accepted on counter zero
  assign dla_evt = (evt_code == `EVT_MEM_UOPS &&
                    (evt_unit_mask == 8'h02 || evt_unit_mask == 8'h04 || evt_unit_mask == 8'h08)) ||
                   (evt_code == `EVT_RECYCLE &&
                    (evt_unit_mask == 8'h01 || evt_unit_mask == 8'h08));
  assign precise_event_sampling_evt = dla_evt ||
    (evt_code == `EVT_BRANCHES &&
     (evt_unit_mask == 8'h00 || evt_unit_mask == 8'h7e || evt_unit_mask == 8'hfe ||
      evt_unit_mask == 8'hf9 || evt_unit_mask == 8'hfd || evt_unit_mask == 8'hfb ||
      evt_unit_mask == 8'heb || evt_unit_mask == 8'hbf || evt_unit_mask == 8'hf7)) ||
    (evt_code == `EVT_MISPRED &&
     (evt_unit_mask == 8'h00 || evt_unit_mask == 8'h7e || evt_unit_mask == 8'hfe ||
      evt_unit_mask == 8'hfb || evt_unit_mask == 8'heb || evt_unit_mask == 8'hf7));

  assign rec_busy = (state_r != S_IDLE);

  // Register port: writes store implemented bits, reads return them
  always @(posedge mclk) begin
    if (!rst_b) begin
      qual0_r <= 64'h0;
      qual1_r <= 64'h0;
      reg_rdata <= 64'h0;
      reg_err <= 1'b0;
    end else if (clk_en) begin
      reg_err <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `QUAL0_ADDR: qual0_r <= reg_wdata & `QUAL0_MASK;
          `QUAL1_ADDR: qual1_r <= reg_wdata & `QUAL1_MASK;
          default: reg_err <= 1'b1;
        endcase
      end else if (reg_rd) begin
        case (reg_addr)
          `QUAL0_ADDR: reg_rdata <= qual0_r;
          `QUAL1_ADDR: reg_rdata <= qual1_r;
          `CAPAB_ADDR: reg_rdata <= capab;
          default: begin
            reg_rdata <= 64'h0;
            reg_err <= 1'b1;
          end
        endcase
      end
    end
  end

  // Qualifier copies move over only between transactions
  always @(posedge mclk) begin
    if (!rst_b) begin
      qual0_act_r <= 64'h0;
      qual1_act_r <= 64'h0;
    end else if (clk_en && !txn_valid) begin
      qual0_act_r <= qual0_r;
      qual1_act_r <= qual1_r;
    end
  end

  // General counters: off-core matching and latency accumulation
  always @(posedge mclk) begin
    if (!rst_b) begin
      gen_count0 <= {CNT_W{1'b0}};
      gen_count1 <= {CNT_W{1'b0}};
    end else if (clk_en) begin
      if (lat_en) begin
        // Counter 0 counts requests, counter 1 weighted outstanding cycles
        if (txn_valid && hit0) begin
          gen_count0 <= gen_count0 + 1'b1;
        end
        gen_count1 <= gen_count1 + {{(CNT_W-8){1'b0}}, outstanding};
      end else begin
        if (txn_valid && ((sel0_q0 && hit0) || (sel0_q1 && hit1))) begin
          gen_count0 <= gen_count0 + 1'b1;
        end
        if (txn_valid && ((sel1_q0 && hit0) || (sel1_q1 && hit1))) begin
          gen_count1 <= gen_count1 + 1'b1;
        end
      end
    end
  end

  // Slot value selection for the record
  always @* begin
    slot_val = 64'h0;
    case (slot_r)
      5'd0: slot_val = flags_r;
      5'd1: slot_val = ip_r;
      5'd18: slot_val = gstat_r;
      5'd19: slot_val = dla_ok_r ? dla_r : 64'h0;
      5'd22: slot_val = evip_r;
      default: begin
        if (slot_r >= 5'd2 && slot_r <= 5'd17) begin
          slot_val = gprs_r[(slot_r - 5'd2) * 64 +: 64];
        end else begin
          slot_val = 64'h0;
        end
      end
    endcase
  end

  // Sampling record sequencer on counter zero
  always @(posedge mclk) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      slot_r <= 5'd0;
      dla_r <= 64'h0;
      dla_ok_r <= 1'b0;
      evip_r <= 64'h0;
      flags_r <= 64'h0;
      ip_r <= 64'h0;
      gprs_r <= {1024{1'b0}};
      gstat_r <= 64'h0;
      rec_valid <= 1'b0;
      rec_offset <= 8'h00;
      rec_data <= 64'h0;
    end else if (clk_en) begin
      case (state_r)
        S_IDLE: begin
          rec_valid <= 1'b0;
          // Only counter zero with sampling enabled triggers
          if (evt_valid && evsel0_en && evsel0_precise_event_sampling && precise_event_sampling_evt &&
              evt_code == evsel0_event && evt_unit_mask == evsel0_unit_mask) begin
            dla_r <= evt_dla;
            dla_ok_r <= dla_evt;
            evip_r <= evt_ip;
            gstat_r <= global_status;
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          // State is taken from the following instruction
          if (next_valid) begin
            flags_r <= next_flags;
            ip_r <= next_ip;
            gprs_r <= next_gprs;
            slot_r <= 5'd0;
            state_r <= S_EMIT;
          end
        end
        S_EMIT: begin
          // One 64-bit slot per accepted beat
          if (!rec_valid || rec_ready) begin
            if (slot_r == `REC_SLOTS) begin
              rec_valid <= 1'b0;
              state_r <= S_IDLE;
            end else begin
              rec_valid <= 1'b1;
              rec_offset <= {slot_r, 3'b000};
              rec_data <= slot_val;
              slot_r <= slot_r + 5'd1;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

endmodule // perf_sampling_offcore

// ### verif/perf_sampling_offcore_properties.sv
`timescale 1ns/1ns
`include "perf_sampling_defs.vh"

// Port-level checks on the register port, grants, counter zero and record beats
module perf_sampling_offcore_properties #(
  parameter CNT_W = 48
) (
  input wire mclk,
  input wire rst_b,
  input wire clk_en,
  input wire reg_wr,
  input wire reg_rd,
  input wire [9:0] reg_addr,
  input wire [63:0] reg_wdata,
  input wire [63:0] reg_rdata,
  input wire reg_err,
  input wire [7:0] evsel0_event,
  input wire [7:0] evsel0_unit_mask,
  input wire evsel0_en,
  input wire [7:0] evsel1_event,
  input wire [7:0] evsel1_unit_mask,
  input wire evsel0_any_ok,
  input wire evsel1_any_ok,
  input wire rec_ready,
  input wire rec_valid,
  input wire [7:0] rec_offset,
  input wire [63:0] rec_data,
  input wire [CNT_W-1:0] gen_count0
);
  // Accepted register strobe
  wire strobe = clk_en && (reg_wr || reg_rd);
  // Address decodes to a real register
  wire mapped = reg_addr == `QUAL0_ADDR || reg_addr == `QUAL1_ADDR || reg_addr == `CAPAB_ADDR;
  // Write to the read-only capability register
  wire cap_wr = clk_en && reg_wr && reg_addr == `CAPAB_ADDR;

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_cap_format: assert property (
    clk_en && reg_rd && !reg_wr && reg_addr == `CAPAB_ADDR |=> reg_rdata[11:8] == `CAPAB_FMT_VAL)
    else $error("capability format field wrong");
  a_cap_readonly: assert property (cap_wr |=> reg_err)
    else $error("capability write not refused");
  a_unmapped_err: assert property (strobe && !mapped |=> reg_err)
    else $error("unmapped access not flagged");
  a_mapped_clean: assert property (strobe && mapped && !cap_wr |=> !reg_err)
    else $error("mapped access flagged");
  a_qual_readback: assert property (
    (clk_en && reg_wr && reg_addr == `QUAL1_ADDR) ##1 !reg_wr
    ##1 (clk_en && reg_rd && !reg_wr && reg_addr == `QUAL1_ADDR)
    |=> reg_rdata == ($past(reg_wdata, 3) & `QUAL1_MASK))
    else $error("qualifier one readback wrong");
  a_any_grant: assert property (
    evsel0_any_ok || evsel1_any_ok |-> (evsel0_any_ok -> evsel0_event == `EVT_CORE_CYC
    && (evsel0_unit_mask == `UNIT_MASK_CORE_CYC || evsel0_unit_mask == `UNIT_MASK_REF_CYC))
    && (evsel1_any_ok -> evsel1_event == `EVT_CORE_CYC
    && (evsel1_unit_mask == `UNIT_MASK_CORE_CYC || evsel1_unit_mask == `UNIT_MASK_REF_CYC)))
    else $error("cross-thread grant on wrong event");
  a_rec_step: assert property (
    rec_valid && rec_ready && clk_en && rec_offset != `REC_RSV2
    |=> rec_valid && rec_offset == $past(rec_offset) + 8'h08)
    else $error("record slot step wrong");
  a_rec_hold: assert property (
    rec_valid && !rec_ready |=> rec_valid && $stable(rec_offset) && $stable(rec_data))
    else $error("record beat dropped while stalled");
  a_idle_count: assert property (!evsel0_en |=> $stable(gen_count0))
    else $error("counter moved while disabled");
endmodule // perf_sampling_offcore_properties

bind perf_sampling_offcore perf_sampling_offcore_properties #(.CNT_W(CNT_W)) u_props (
  .mclk, .rst_b, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_err,
  .evsel0_event, .evsel0_unit_mask, .evsel0_en, .evsel1_event, .evsel1_unit_mask,
  .evsel0_any_ok, .evsel1_any_ok, .rec_ready, .rec_valid, .rec_offset, .rec_data,
  .gen_count0);

// ### verif/perf_sampling_offcore_test.sv
`timescale 1ns/1ns
`include "perf_sampling_defs.vh"

module perf_sampling_offcore_test;
  reg mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  reg [9:0] reg_addr = 10'h0;
  reg [63:0] reg_wdata = 64'h0, evt_dla = 64'h0, evt_ip = 64'h0, next_flags = 64'h0;
  reg [63:0] next_ip = 64'h0, global_status = 64'h0, q0, q1, v;
  reg [7:0] evsel0_event = 8'h0, evsel0_unit_mask = 8'h0, evsel1_event = 8'h0, evsel1_unit_mask = 8'h0;
  reg [7:0] evt_code = 8'h0, evt_unit_mask = 8'h0, outstanding = 8'h0;
  reg evsel0_en = 1'b0, evsel0_any = 1'b0, evsel0_precise_event_sampling = 1'b0, evsel1_en = 1'b0, evsel1_any = 1'b0;
  reg evt_valid = 1'b0, next_valid = 1'b0, txn_valid = 1'b0, rec_ready = 1'b0;
  reg [2:0] fixed_any_req = 3'h0;
  reg [1023:0] next_gprs = 1024'h0, g;
  reg [15:0] txn_req = 16'h0;
  reg [14:0] txn_sup = 15'h0;
  reg [6:0] txn_snp = 7'h0;
  wire [63:0] reg_rdata, rec_data;
  wire [47:0] gen_count0, gen_count1;
  wire [7:0] rec_offset;
  wire [2:0] fixed_any_ok;
  wire reg_err, rec_valid, rec_busy, evsel0_any_ok, evsel1_any_ok;
  integer errors = 0, comparisons = 0, cnt0 = 0, cnt1 = 0, i, k, n, sw;
  reg [63:0] exp_q[$]; // Expected record slots
  reg [15:0] any_tab [0:3] = '{16'h3c00, 16'h3c01, 16'hb701, 16'hc400}; // Event, unit mask
  reg [15:0] smp_tab [0:3] = '{16'hc400, 16'hc57e, 16'h0402, 16'h0308}; // Sampled events

  perf_sampling_offcore DUT (.mclk, .rst_b, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_err, .evsel0_event, .evsel0_unit_mask, .evsel0_en, .evsel0_any, .evsel0_precise_event_sampling,
    .evsel1_event, .evsel1_unit_mask, .evsel1_en, .evsel1_any, .fixed_any_req, .evt_valid, .evt_code,
    .evt_unit_mask, .evt_dla, .evt_ip, .next_valid, .next_flags, .next_ip, .next_gprs, .global_status,
    .txn_valid, .txn_req, .txn_sup, .txn_snp, .outstanding, .rec_ready, .rec_valid, .rec_offset,
    .rec_data, .rec_busy, .gen_count0, .gen_count1, .fixed_any_ok, .evsel0_any_ok, .evsel1_any_ok);

  // 25 MHz core clock
  always #20 mclk = ~mclk;

  // Compare and count
  task chk(input [63:0] s, input [63:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Counts, verdict, stop
  task end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle write strobe, refusal seen the cycle after
  task wr(input [9:0] a, input [63:0] d, input err);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1 chk(64'(reg_err), 64'(err));
  endtask

  // One-cycle read strobe, masked data checked when not refused
  task rd(input [9:0] a, input [63:0] e, input [63:0] m, input err);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(64'(reg_err), 64'(err));
    if (!err) chk(reg_rdata & m, e);
  endtask

  // Model of a qualifier match: every group must hit
  function bit hit(input [63:0] q, input [15:0] r, input [14:0] s, input [6:0] p);
    hit = |(q[15:0] & r) && |(q[30:16] & s) && |(q[37:31] & p);
  endfunction

  // One transaction with a single attribute bit per group
  task txn;
    reg [15:0] r;
    reg [14:0] s;
    reg [6:0] p;
    r = 16'h1 << ($urandom % 16);
    s = 15'h1 << ($urandom % 15);
    p = 7'h1 << ($urandom % 7);
    if (hit(sw ? q1 : q0, r, s, p)) cnt0++;
    if (hit(sw ? q0 : q1, r, s, p)) cnt1++;
    @(posedge mclk);
    txn_valid <= 1'b1;
    txn_req <= r;
    txn_sup <= s;
    txn_snp <= p;
    @(posedge mclk);
    txn_valid <= 1'b0;
  endtask

  initial begin
    i = $urandom(47858);
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`QUAL0_ADDR, 64'h0, ~64'h0, 1'b0);
    rd(`CAPAB_ADDR, 64'h200, 64'hf00, 1'b0);
    wr(`CAPAB_ADDR, ~64'h0, 1'b1);
    rd(`CAPAB_ADDR, 64'h200, 64'hf00, 1'b0);
    rd(10'h1a8, 64'h0, 64'h0, 1'b1);
    // Cross-thread grants on cycle events only for general counters, fixed grants follow requests
    for (k = 0; k < 4; k++) begin
      v = 64'(any_tab[k]);
      @(posedge mclk);
      {evsel0_event, evsel0_unit_mask} <= v[15:0];
      {evsel1_event, evsel1_unit_mask} <= v[15:0];
      {evsel0_any, evsel1_any} <= 2'h3;
      fixed_any_req <= 3'($urandom);
      @(posedge mclk);
      #1 chk(64'(evsel0_any_ok), 64'(k < 2));
      chk(64'(evsel1_any_ok), 64'(k < 2));
      chk(64'(fixed_any_ok), 64'(fixed_any_req));
    end
    {evsel0_any, evsel1_any} <= 2'h0;
    // Off-core counting, both counters against both qualifiers
    for (sw = 0; sw < 2; sw++) begin
      q0 = {$urandom, $urandom} & ~(64'h1 << 38) & `QUAL0_MASK;
      q1 = {$urandom, $urandom} & `QUAL1_MASK;
      wr(`QUAL0_ADDR, q0, 1'b0);
      wr(`QUAL1_ADDR, q1, 1'b0);
      q0 = q0 & `QUAL0_MASK;
      q1 = q1 & `QUAL1_MASK;
      rd(`QUAL0_ADDR, q0, ~64'h0, 1'b0);
      rd(`QUAL1_ADDR, q1, ~64'h0, 1'b0);
      @(posedge mclk);
      {evsel0_event, evsel1_event} <= {`EVT_OFFCORE, `EVT_OFFCORE};
      evsel0_unit_mask <= sw ? `UNIT_MASK_QUAL1 : `UNIT_MASK_QUAL0;
      evsel1_unit_mask <= sw ? `UNIT_MASK_QUAL0 : `UNIT_MASK_QUAL1;
      {evsel0_en, evsel1_en} <= 2'h3;
      for (i = 0; i < 40; i++) txn;
      repeat (2) @(posedge mclk);
      #1 chk(64'(gen_count0), 64'(cnt0));
      chk(64'(gen_count1), 64'(cnt1));
    end
    // Latency mode: counter one sums outstanding each cycle
    wr(`QUAL0_ADDR, `QUAL0_MASK, 1'b0);
    n = $urandom % 256;
    @(posedge mclk);
    {evsel0_unit_mask, evsel1_unit_mask} <= {`UNIT_MASK_QUAL0, `UNIT_MASK_QUAL0};
    outstanding <= 8'(n);
    #1 v = 64'(gen_count1);
    repeat (10) @(posedge mclk);
    #1 chk(64'(gen_count1), v + 64'(10 * n));
    chk(64'(gen_count0), 64'(cnt0));
    @(posedge mclk);
    evsel1_en <= 1'b0;
    outstanding <= 8'h0;
    // Sampling records on counter zero
    for (k = 0; k < 4; k++) begin
      v = 64'(smp_tab[k]);
      for (i = 0; i < 32; i++) g[32*i+:32] = $urandom;
      @(posedge mclk);
      {evsel0_event, evsel0_unit_mask, evsel0_precise_event_sampling} <= {v[15:0], 1'b1};
      @(posedge mclk);
      {evt_valid, evt_code, evt_unit_mask} <= {1'b1, v[15:0]};
      {evt_dla, evt_ip, next_flags} <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      {next_ip, global_status, next_gprs} <= {$urandom, $urandom, $urandom, $urandom, g};
      @(posedge mclk);
      evt_valid <= 1'b0;
      next_valid <= 1'b1;
      @(posedge mclk);
      next_valid <= 1'b0;
      #1 chk(64'(rec_busy), 64'h1);
      exp_q = {};
      for (n = 0; n < 24; n++) exp_q.push_back(n == 0 ? next_flags : n == 1 ? next_ip :
        n < 18 ? g[64*(n-2)+:64] : n == 18 ? global_status :
        n == 19 ? (k > 1 ? evt_dla : 64'h0) : n == 22 ? evt_ip : 64'h0);
      n = 0;
      for (i = 0; i < 400 && n < 24; i++) begin
        @(posedge mclk);
        rec_ready <= 1'($urandom);
        #1;
        if (rec_valid === 1'b1 && rec_ready) begin
          chk(64'(rec_offset), 64'(n * 8));
          if (n < 20 || n == 22) chk(rec_data, exp_q[n]);
          n++;
        end
      end
      if (n < 24) begin
        errors++;
        end_of_test;
      end
    end
    end_of_test;
  end
endmodule // perf_sampling_offcore_test
